// file: hdl/jshf_pkg.sv
package jshf_pkg;

    // Block and multiblock geometry
    localparam int unsigned BLK_DATA_W = 64;
    localparam int unsigned BLK_HDR_W = 2;
    localparam int unsigned MB_BLOCKS = 32;
    localparam int unsigned MB_IDX_W = 5;
    localparam int unsigned EMB_MULTIBLOCKS = 1;
    localparam int unsigned FIFO_DEPTH = 4;

    // Sync header codes, bit 0 is the first sent header position
    localparam logic [1:0] SH_ONE = 2'h2;
    localparam logic [1:0] SH_ZERO = 2'h1;

    // CRC-12, printed in implicit-one form
    localparam int unsigned CRC_W = 12;
    localparam logic [11:0] CRC_POLY_IMPL = 12'h987;
    localparam logic [11:0] CRC_TAPS = {CRC_POLY_IMPL[10:0], 1'b1};
    localparam logic [11:0] CRC_INIT = 12'h000;
    localparam int unsigned FEC_W = 26;

    // Sync header stream word positions
    localparam int unsigned SHS_EXT_END_POS = 22;
    localparam int unsigned SHS_END_LSB = 27;
    localparam logic [4:0] SHS_END_PATTERN = 5'h10;
    localparam logic [31:0] SHS_CRC_ONES = 32'h80A88888;
    localparam logic [MB_IDX_W-1:0] MB_LAST_IDX = 5'h1F;
    localparam logic [MB_IDX_W-1:0] MB_FIRST_IDX = 5'h00;

    typedef struct packed {
        logic [BLK_HDR_W-1:0] hdr;
        logic [BLK_DATA_W-1:0] data;
    } jshf_blk_s;

    typedef enum logic [1:0] {
        ST_UNALIGNED = 2'h1,
        ST_ALIGNED = 2'h2
    } jshf_state_e;

endpackage

// file: hdl/jshf_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module jshf_fifo #(
    parameter int unsigned WIDTH = 64,
    parameter int unsigned DEPTH = 4
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Fill side
    input wire logic wr_valid_in,
    input wire logic [WIDTH-1:0] wr_data_in,
    output logic wr_ready_out,
    // Drain side
    output logic rd_valid_out,
    output logic [WIDTH-1:0] rd_data_out,
    input wire logic rd_ready_in
);
    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wr_ptr_ff, nxt_wr_ptr;
    logic [AW-1:0] rd_ptr_ff, nxt_rd_ptr;
    logic [AW:0] count_ff, nxt_count;
    logic push, pop;

    assign wr_ready_out = (count_ff != (AW+1)'(DEPTH));
    assign rd_valid_out = (count_ff != '0);
    assign rd_data_out = mem_ff[rd_ptr_ff];

    always_comb begin
        push = wr_valid_in && wr_ready_out;
        pop = rd_valid_out && rd_ready_in;
        nxt_wr_ptr = wr_ptr_ff;
        nxt_rd_ptr = rd_ptr_ff;
        if (push) begin
            nxt_wr_ptr = (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
        end
        if (pop) begin
            nxt_rd_ptr = (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
        end
        nxt_count = count_ff + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
        end else begin
            wr_ptr_ff <= nxt_wr_ptr;
            rd_ptr_ff <= nxt_rd_ptr;
            count_ff <= nxt_count;
        end
    end

    // Storage has no reset; valid gates it
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= wr_data_in;
        end
    end
endmodule // jshf_fifo
`default_nettype wire

// file: hdl/jshf_framer.sv
// Functional notes
// - Multiblock is 32 blocks, counted here.
// - One multiblock per extended multiblock, fixed.
// - Extended multiblock holds whole frames; source's job.
// - SYSREF resets local extended multiblock clock phase.
// - Clock period is one 32-block multiblock.
// - Header bits always complementary, 01 or 10.
// - Header 01 sends one, 10 sends zero.
// - 32 header bits form one stream word.
// - Stream carries CRC-12 or FEC parity only.
// - Stream word ends with pattern 00001.
// - Bit 22 set in last multiblock only.
// - CRC over 2048 data bits, sent next multiblock.
// - CRC polynomial is 0x987.
// - CRC cleared before each multiblock, read after.
// - Parity bits at 0-2,4-6,8-10,12-14, MSB first.
// - Command positions sent as zero in CRC mode; FEC mode fills 16-21,24-26 with parity.
// - Fixed ones at 3,7,11,15,19,21,23,31 in CRC mode.
// - Scrambled data first, header prefixed after.
`timescale 1ns/1ps
`default_nettype none
module jshf_framer
    import jshf_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // SYSREF pin
    input wire logic sysref_in,
    // Scrambled block input
    input wire logic blk_valid_in,
    input wire logic [BLK_DATA_W-1:0] blk_data_in,
    output logic blk_ready_out,
    // Parity mode and external FEC parity of previous multiblock
    input wire logic fec_mode_in,
    input wire logic [FEC_W-1:0] fec_parity_in,
    // 66-bit block output
    output logic out_valid_out,
    output jshf_blk_s out_block_out,
    input wire logic out_ready_in,
    // Status
    output logic local_ext_multiblock_clock_out,
    output logic [MB_IDX_W-1:0] mb_index_out,
    output logic local_ext_multiblock_clock_aligned_out,
    output logic [CRC_W-1:0] crc_parity_out,
    output logic parity_valid_out
);

    // SYSREF synchroniser; first stage read only by the second
    logic sysref_meta_ff;
    logic sysref_sync_ff;
    logic sysref_prev_ff;
    logic sysref_edge;

    // Input buffer signals
    logic fifo_valid;
    logic [BLK_DATA_W-1:0] fifo_data;
    logic take;

    // Framer state
    jshf_state_e state_ff, nxt_state;
    logic [MB_IDX_W-1:0] blk_idx_ff, nxt_blk_idx;
    logic [CRC_W-1:0] crc_ff, nxt_crc;
    logic [CRC_W-1:0] parity_ff, nxt_parity;
    logic parity_ok_ff, nxt_parity_ok;
    logic [31:0] shw_ff, nxt_shw;
    logic realign_ff, nxt_realign;
    logic out_valid_ff, nxt_out_valid;
    jshf_blk_s out_blk_ff, nxt_out_blk;
    logic local_ext_multiblock_clock_ff, nxt_local_ext_multiblock_clock;

    // Working values
    logic [MB_IDX_W-1:0] idx;
    logic [CRC_W-1:0] crc_base;
    logic [CRC_W-1:0] crc_new;
    logic [31:0] word;
    logic hbit;

    // Bitwise CRC, oldest data bit first
    function automatic logic [CRC_W-1:0] crc_step(input logic [CRC_W-1:0] crc_i,
                                                  input logic [BLK_DATA_W-1:0] d);
        logic [CRC_W-1:0] c;
        logic fb;
        c = crc_i;
        fb = 1'b0;
        for (int i = BLK_DATA_W - 1; i >= 0; i--) begin
            fb = c[CRC_W-1] ^ d[i];
            c = {c[CRC_W-2:0], 1'b0} ^ (fb ? CRC_TAPS : CRC_INIT);
        end
        return c;
    endfunction

    // Build one sync header stream word for a multiblock
    function automatic logic [31:0] build_word(input logic fec,
                                               input logic [CRC_W-1:0] crc,
                                               input logic [FEC_W-1:0] fp);
        logic [31:0] w;
        w = '0;
        if (fec) begin
            w[21:0] = {fp[4], fp[5], fp[6], fp[7], fp[8], fp[9], fp[10], fp[11],
                       fp[12], fp[13], fp[14], fp[15], fp[16], fp[17], fp[18], fp[19],
                       fp[20], fp[21], fp[22], fp[23], fp[24], fp[25]};
            w[23] = fp[3];
            w[26:24] = {fp[0], fp[1], fp[2]};
        end else begin
            w = SHS_CRC_ONES;
            w[2:0] = {crc[9], crc[10], crc[11]};
            w[6:4] = {crc[6], crc[7], crc[8]};
            w[10:8] = {crc[3], crc[4], crc[5]};
            w[14:12] = {crc[0], crc[1], crc[2]};
        end
        w[SHS_EXT_END_POS] = (EMB_MULTIBLOCKS == 1);
        w[31:SHS_END_LSB] = SHS_END_PATTERN;
        return w;
    endfunction

    // Four-word buffer ahead of the framer; a stalled sink fills it
    jshf_fifo #(
        .WIDTH(BLK_DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .wr_valid_in(blk_valid_in),
        .wr_data_in(blk_data_in),
        .wr_ready_out(blk_ready_out),
        .rd_valid_out(fifo_valid),
        .rd_data_out(fifo_data),
        .rd_ready_in(take)
    );

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            sysref_meta_ff <= 1'b0;
            sysref_sync_ff <= 1'b0;
            sysref_prev_ff <= 1'b0;
        end else begin
            sysref_meta_ff <= sysref_in;
            sysref_sync_ff <= sysref_meta_ff;
            sysref_prev_ff <= sysref_sync_ff;
        end
    end

    assign sysref_edge = sysref_sync_ff && !sysref_prev_ff;

    // A block moves when the output register is free or drained
    assign take = fifo_valid && (!out_valid_ff || out_ready_in);

    always_comb begin
        idx = realign_ff ? MB_FIRST_IDX : blk_idx_ff;
        crc_base = (idx == MB_FIRST_IDX) ? CRC_INIT : crc_ff;
        crc_new = crc_step(crc_base, fifo_data);
        // Parity withheld until a full multiblock since alignment
        word = (idx == MB_FIRST_IDX) ?
               build_word(fec_mode_in, (parity_ok_ff && !realign_ff) ? parity_ff : CRC_INIT,
                          fec_parity_in) : shw_ff;
        hbit = word[idx];

        nxt_state = state_ff;
        nxt_blk_idx = blk_idx_ff;
        nxt_crc = crc_ff;
        nxt_parity = parity_ff;
        nxt_parity_ok = parity_ok_ff;
        nxt_shw = shw_ff;
        nxt_out_valid = out_valid_ff;
        nxt_out_blk = out_blk_ff;
        nxt_local_ext_multiblock_clock = 1'b0;
        // Edge in the consuming cycle keeps the request
        nxt_realign = sysref_edge || (realign_ff && !take);

        if (out_valid_ff && out_ready_in) begin
            nxt_out_valid = 1'b0;
        end

        if (take) begin
            nxt_out_valid = 1'b1;
            nxt_out_blk.data = fifo_data;
            nxt_out_blk.hdr = hbit ? SH_ONE : SH_ZERO;
            nxt_shw = word;
            nxt_crc = crc_new;
            nxt_local_ext_multiblock_clock = (idx == MB_FIRST_IDX);
            if (realign_ff) begin
                nxt_parity_ok = 1'b0;
            end
            if (idx == MB_LAST_IDX) begin
                nxt_blk_idx = MB_FIRST_IDX;
                nxt_parity = crc_new;
                nxt_parity_ok = 1'b1;
            end else begin
                nxt_blk_idx = idx + 1'b1;
            end
        end

        case (state_ff)
            ST_UNALIGNED: begin
                if (realign_ff && take) begin
                    nxt_state = ST_ALIGNED;
                end
            end
            ST_ALIGNED: begin
                nxt_state = ST_ALIGNED;
            end
            default: begin
                nxt_state = ST_UNALIGNED;
            end
        endcase
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state_ff <= ST_UNALIGNED;
            blk_idx_ff <= MB_FIRST_IDX;
            crc_ff <= CRC_INIT;
            parity_ff <= CRC_INIT;
            parity_ok_ff <= 1'b0;
            shw_ff <= '0;
            realign_ff <= 1'b0;
            out_valid_ff <= 1'b0;
            out_blk_ff <= '0;
            local_ext_multiblock_clock_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            blk_idx_ff <= nxt_blk_idx;
            crc_ff <= nxt_crc;
            parity_ff <= nxt_parity;
            parity_ok_ff <= nxt_parity_ok;
            shw_ff <= nxt_shw;
            realign_ff <= nxt_realign;
            out_valid_ff <= nxt_out_valid;
            out_blk_ff <= nxt_out_blk;
            local_ext_multiblock_clock_ff <= nxt_local_ext_multiblock_clock;
        end
    end

    assign out_valid_out = out_valid_ff;
    assign out_block_out = out_blk_ff;
    assign local_ext_multiblock_clock_out = local_ext_multiblock_clock_ff;
    assign mb_index_out = blk_idx_ff;
    assign local_ext_multiblock_clock_aligned_out = (state_ff == ST_ALIGNED);
    assign crc_parity_out = parity_ff;
    assign parity_valid_out = parity_ok_ff;

endmodule // jshf_framer
`default_nettype wire

// file: verif/jshf_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module jshf_monitor
    import jshf_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Lane and status
    input wire logic out_valid_out,
    input wire jshf_blk_s out_block_out,
    input wire logic out_ready_in,
    input wire logic fec_mode_in,
    input wire logic local_ext_multiblock_clock_out,
    input wire logic [MB_IDX_W-1:0] mb_index_out
);
    localparam logic [31:0] CMD_MASK = 32'h07170000;
    logic [4:0] idx;
    logic [1:0] h;
    logic fec_ff;
    logic nxt_fec;
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    // Held block was taken just before the index moved on
    assign idx = mb_index_out - 5'h01;
    assign h = out_block_out.hdr;
    assign nxt_fec = local_ext_multiblock_clock_out ? fec_mode_in : fec_ff;
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            fec_ff <= 1'b0;
        end else begin
            fec_ff <= nxt_fec;
        end
    end
    sequence s_stall;
        out_valid_out && !out_ready_in;
    endsequence
    AST_HDR_COMPL: assert property (out_valid_out |-> h == SH_ONE || h == SH_ZERO)
        else $error("header not complementary");
    AST_HOLD: assert property (s_stall |=> out_valid_out && $stable(out_block_out))
        else $error("block not held");
    AST_LOCAL_EXT_MULTIBLOCK_CLOCK_IDX: assert property (local_ext_multiblock_clock_out |-> out_valid_out && mb_index_out == 5'h01)
        else $error("clock pulse off block zero");
    AST_MULTIBLOCK_END_PATTERN_ZERO: assert property (out_valid_out && idx inside {[5'h1B:5'h1E]} |-> h == SH_ZERO)
        else $error("end pattern zero wrong");
    AST_MULTIBLOCK_END_PATTERN_ONE: assert property (out_valid_out && idx == MB_LAST_IDX |-> h == SH_ONE)
        else $error("end pattern one wrong");
    AST_EXT_END: assert property (out_valid_out && idx == 5'h16 |-> h == SH_ONE)
        else $error("extended end bit wrong");
    AST_CRC_ONES: assert property (out_valid_out && !fec_ff && SHS_CRC_ONES[idx] |-> h == SH_ONE)
        else $error("fixed one wrong");
    AST_CMD_ZERO: assert property (out_valid_out && !fec_ff && CMD_MASK[idx] |-> h == SH_ZERO)
        else $error("command bit not zero");
endmodule // jshf_monitor
bind jshf_framer jshf_monitor u_mon (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .out_valid_out(out_valid_out),
    .out_block_out(out_block_out), .out_ready_in(out_ready_in), .fec_mode_in(fec_mode_in),
    .local_ext_multiblock_clock_out(local_ext_multiblock_clock_out), .mb_index_out(mb_index_out));
`default_nettype wire

// file: verif/jshf_rx_model.sv
`timescale 1ns/1ps
`default_nettype none
module jshf_rx_model
    import jshf_pkg::*;
(
    // Clock, reset and pacing
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic stall_in,
    // Lane from framer
    input wire logic valid_in,
    input wire jshf_blk_s blk_in,
    input wire logic local_ext_multiblock_clock_in,
    output logic ready_out,
    // Decoded multiblock
    output logic [31:0] word_out,
    output logic [11:0] crc_last_out,
    output int mb_cnt_out,
    output int bad_out
);
    logic [31:0] w;
    logic [11:0] acc;
    logic [4:0] idx;
    logic zero;
    assign ready_out = !stall_in;
    always @(posedge clk_in or posedge sys_rst_in) begin : rx
        logic [4:0] k;
        integer i;
        if (sys_rst_in) begin
            idx = 5'h00;
            zero = 1'b0;
            mb_cnt_out <= 0;
            bad_out <= 0;
            crc_last_out <= 12'h000;
            word_out <= 32'h0;
        end else if (valid_in && ready_out) begin
            k = (local_ext_multiblock_clock_in || zero) ? 5'h00 : idx;
            acc = (k == 5'h00) ? 12'h000 : acc;
            // Serial divider, bit 63 enters first
            for (i = 63; i >= 0; i--) begin
                acc = {acc[10:0], 1'b0} ^ ((acc[11] ^ blk_in.data[i]) ? 12'h30F : 12'h000);
            end
            w[k] = (blk_in.hdr == SH_ONE);
            if (blk_in.hdr[0] == blk_in.hdr[1]) begin
                bad_out <= bad_out + 1;
            end
            if (k == 5'h1F) begin
                word_out <= w;
                crc_last_out <= acc;
                mb_cnt_out <= mb_cnt_out + 1;
            end
            idx = k + 5'h01;
            zero = 1'b0;
        end else if (local_ext_multiblock_clock_in) begin
            zero = 1'b1;
        end
    end
endmodule // jshf_rx_model
`default_nettype wire

// file: verif/jshf_framer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module jshf_framer_tb
    import jshf_pkg::*;
;
    typedef struct packed {
        logic fec;
        logic [25:0] fp;
        logic zc;
    } jshf_row_s;
    localparam jshf_row_s ROWS [4] = '{'{1'b0, 26'h0, 1'b1}, '{1'b0, 26'h0, 1'b0},
        '{1'b1, 26'h2A5F0C3, 1'b0}, '{1'b0, 26'h0, 1'b0}};
    logic clk_in, sys_rst_in, sysref_in, blk_valid_in, blk_ready_out, fec_mode_in, hold;
    logic out_valid_out, out_ready_in, local_ext_multiblock_clock, aligned, pvalid;
    logic [63:0] blk_data_in;
    logic [25:0] fec_parity_in;
    logic [MB_IDX_W-1:0] mb_index_out;
    logic [11:0] crc_parity_out, crc_last;
    logic [31:0] word;
    logic [1:0] cyc = 2'h0;
    jshf_blk_s out_block_out;
    int mb_cnt, bad, errors, checks, n, t;
    jshf_framer u_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .sysref_in(sysref_in),
        .blk_valid_in(blk_valid_in), .blk_data_in(blk_data_in), .blk_ready_out(blk_ready_out),
        .fec_mode_in(fec_mode_in), .fec_parity_in(fec_parity_in), .out_valid_out(out_valid_out),
        .out_block_out(out_block_out), .out_ready_in(out_ready_in), .local_ext_multiblock_clock_out(local_ext_multiblock_clock),
        .mb_index_out(mb_index_out), .local_ext_multiblock_clock_aligned_out(aligned), .crc_parity_out(crc_parity_out),
        .parity_valid_out(pvalid));
    // Far side pauses one cycle in four, or fully while hold is set
    jshf_rx_model u_rx (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .stall_in(hold || cyc == 2'h3),
        .valid_in(out_valid_out), .blk_in(out_block_out), .local_ext_multiblock_clock_in(local_ext_multiblock_clock), .ready_out(out_ready_in),
        .word_out(word), .crc_last_out(crc_last), .mb_cnt_out(mb_cnt), .bad_out(bad));
    initial begin
        clk_in = 1'b0;
        forever begin
            #12.5 clk_in = ~clk_in;
        end
    end
    always @(posedge clk_in) begin
        cyc <= cyc + 2'h1;
    end
    task automatic results();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic guard(input int lim);
        if (t >= lim) begin
            chk("wait", 32'h0, 32'h1);
            results();
        end
    endtask
    function automatic logic [31:0] exp_word(input logic f, input logic [11:0] c, input logic [25:0] p);
        logic [31:0] w;
        w = f ? 32'h80400000 : 32'h80E88888;
        for (int j = 0; j < 22; j++) begin
            if (f) begin
                w[j] = p[25 - j];
            end else if (j < 12) begin
                w[j + j / 3] = c[11 - j];
            end
        end
        if (f) begin
            w[26:23] = {p[0], p[1], p[2], p[3]};
        end
        return w;
    endfunction
    task automatic send(input logic [63:0] d);
        logic ok;
        blk_valid_in <= 1'b1;
        blk_data_in <= d;
        t = 0;
        ok = 1'b0;
        // Ready judged settled, before the edge that takes the word
        do begin
            #1;
            ok = (blk_ready_out === 1'b1);
            @(posedge clk_in);
            t++;
        end while (!ok && t < 100);
        guard(100);
    endtask
    task automatic run_mb(input logic f, input logic [25:0] p, input logic zc);
        logic [11:0] c;
        c = zc ? 12'h000 : crc_last;
        fec_mode_in <= f;
        fec_parity_in <= p;
        n = mb_cnt;
        for (int i = 0; i < 32; i++) begin
            send({8'hC3, 24'(n), 32'(i) * 32'h9E3779B9});
        end
        blk_valid_in <= 1'b0;
        t = 0;
        while (mb_cnt <= n && t < 2000) begin
            @(posedge clk_in);
            t++;
        end
        guard(2000);
        chk("stream word", exp_word(f, c, p), word);
        chk("parity", {20'h0, crc_last}, {20'h0, crc_parity_out});
        chk("parity valid", 32'h1, {31'h0, pvalid});
        chk("bad headers", 32'h0, bad);
    endtask
    task automatic pulse();
        sysref_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        sysref_in <= 1'b0;
        repeat (6) @(posedge clk_in);
    endtask
    initial begin
        {sys_rst_in, sysref_in, blk_valid_in, fec_mode_in, hold} = 5'h10;
        {blk_data_in, fec_parity_in, errors, checks} = '0;
        repeat (20) @(posedge clk_in);
        chk("valid in reset", 32'h0, {31'h0, out_valid_out});
        chk("ready in reset", 32'h1, {31'h0, blk_ready_out});
        $display("reset test done");
        sys_rst_in <= 1'b0;
        pulse();
        foreach (ROWS[r]) begin
            run_mb(ROWS[r].fec, ROWS[r].fp, ROWS[r].zc);
            $display("row %0d done", r);
        end
        chk("aligned", 32'h1, {31'h0, aligned});
        hold <= 1'b1;
        blk_valid_in <= 1'b1;
        n = 0;
        repeat (10) begin
            #1;
            n += int'(blk_ready_out === 1'b1);
            @(posedge clk_in);
        end
        chk("taken while stalled", 32'h5, n);
        blk_valid_in <= 1'b0;
        hold <= 1'b0;
        t = 0;
        do begin
            @(posedge clk_in);
            t++;
        end while (out_valid_out !== 1'b0 && t < 200);
        guard(200);
        chk("drained", 32'h1, {31'h0, blk_ready_out});
        $display("buffer test done");
        // Realign mid-multiblock, parity field restarts at zero
        pulse();
        run_mb(1'b0, 26'h0, 1'b1);
        $display("realign test done");
        results();
    end
endmodule // jshf_framer_tb
`default_nettype wire
